// *** rtl/ics_pkg.sv ***
/*
 * Constants, register map and types for the I/O channel supervision block.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none

package ics_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int TICK_US = 100;
	localparam int HOLD_1MS_US = 1000;
	localparam int HOLD_15MS_US = 15000;
	localparam int HOLD_100MS_US = 100000;
	localparam int HOLD_200MS_US = 200000;
	localparam int SAVE_PERIOD_S = 3600;
	localparam int TICK_CYC_DEF = TICK_US * CLK_MHZ;
	localparam int SAVE_TICKS_DEF = SAVE_PERIOD_S * (1000000 / TICK_US);
	localparam logic [11:0] HOLD_TICKS_1MS = 12'(HOLD_1MS_US / TICK_US);
	localparam logic [11:0] HOLD_TICKS_15MS = 12'(HOLD_15MS_US / TICK_US);
	localparam logic [11:0] HOLD_TICKS_100MS = 12'(HOLD_100MS_US / TICK_US);
	localparam logic [11:0] HOLD_TICKS_200MS = 12'(HOLD_200MS_US / TICK_US);

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OUT_DATA = 8'h04;
	localparam logic [7:0] ADDR_FAULT_FB = 8'h08;
	localparam logic [7:0] ADDR_IDLE_FB = 8'h0c;
	localparam logic [7:0] ADDR_CNT_LIMIT = 8'h10;
	localparam logic [7:0] ADDR_CNT_SEL = 8'h14;
	localparam logic [7:0] ADDR_CNT_DATA = 8'h18;
	localparam logic [7:0] ADDR_RANGE = 8'h1c;
	localparam logic [7:0] ADDR_IN_STATE = 8'h20;
	localparam logic [7:0] ADDR_UNIT_ERR = 8'h24;
	localparam logic [7:0] ADDR_OPEN_ERR = 8'h28;
	localparam logic [7:0] ADDR_CNT_ERR = 8'h2c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

	// ==========================================================
	// Field layouts and reset values
	localparam int IRQ_W = 6;
	localparam int IRQ_SHORT = 0;
	localparam int IRQ_SUPPLY = 1;
	localparam int IRQ_OPEN = 2;
	localparam int IRQ_COUNT = 3;
	localparam int IRQ_SAVE = 4;
	localparam int IRQ_INPUT = 5;
	localparam logic [31:0] CNT_SCALE = 32'd1000;
	localparam logic [15:0] CNT_LIMIT_RST = 16'hfde8;
	localparam logic [15:0] ADC_MIN = 16'h8000;
	localparam logic [15:0] ADC_MAG_MAX = 16'h7fff;
	localparam logic SHORT_POLICY_MANUAL = 1'b1;

	typedef enum logic [1:0] {
		FB_CLEAR = 2'b00,
		FB_HOLD = 2'b01,
		FB_DRIVE_ON_FORCED = 2'b10
	} ics_fallback_type;

	typedef enum logic [1:0] {
		FMT_OFFSET_BIN = 2'b00,
		FMT_SIGN_MAG = 2'b01,
		FMT_TWOS_COMP = 2'b10
	} ics_format_type;

	typedef enum logic [1:0] {
		HOLD_1MS = 2'b00,
		HOLD_15MS = 2'b01,
		HOLD_100MS = 2'b10,
		HOLD_200MS = 2'b11
	} ics_hold_type;

	typedef enum logic [2:0] {
		RNG_PM10V = 3'b000,
		RNG_PM5V = 3'b001,
		RNG_PM20MA = 3'b010,
		RNG_0_10V = 3'b011,
		RNG_0_5V = 3'b100,
		RNG_1_5V = 3'b101,
		RNG_0_20MA = 3'b110,
		RNG_4_20MA = 3'b111
	} ics_range_type;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} ics_bus_state_type;

	typedef struct packed {
		logic [1:0] data_format;
		logic [1:0] input_hold_time_sel;
		logic count_outputs;
		logic hold_prio_handheld;
		logic counter_check_en;
		logic supply_short_detect_en;
		logic open_load_detect_en;
		logic short_restart_policy;
		logic output_short_detect_en;
	} ics_ctrl_type;

	localparam int CTRL_W = $bits(ics_ctrl_type);
	localparam ics_ctrl_type CTRL_RST = 11'h089;

endpackage : ics_pkg

`default_nettype wire

// *** rtl/ics_chan_mon.sv ***
/*
 * Per-channel monitor: input synchroniser, change hold and ON counter.
 * Assumes tick_i is a one-cycle pulse every TICK_US microseconds.
 */
`default_nettype none

module ics_chan_mon import ics_pkg::*; #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Channel
	input wire logic pin_i,
	input wire logic drive_i,
	input wire logic tick_i,
	input wire logic [11:0] hold_ticks_i,
	// Counter control
	input wire logic count_outputs_i,
	input wire logic check_en_i,
	input wire logic preload_i,
	input wire logic [CNT_W-1:0] preload_val_i,
	input wire logic [CNT_W-1:0] limit_i,
	// Results
	output logic level_o,
	output logic changed_o,
	output logic cnt_err_o,
	output logic [CNT_W-1:0] count_o
);

	logic sync1_reg, sync2_reg;
	logic level_reg, level_next;
	logic changed_reg, changed_next;
	logic [11:0] hold_reg, hold_next;
	logic src_prev_reg, src;
	logic [CNT_W-1:0] count_reg, count_next;
	logic err_reg, err_next;

	// ==========================================================
	// Hold and counter
	always_comb begin
		level_next = level_reg;
		hold_next = hold_reg;
		changed_next = 1'b0;
		if (hold_reg != 12'h000) begin
			if (tick_i) begin
				hold_next = hold_reg - 12'h001;
			end
		end else if (sync2_reg != level_reg) begin
			// A change still present when the hold ends is taken then.
			level_next = sync2_reg;
			hold_next = hold_ticks_i;
			changed_next = 1'b1;
		end
		src = count_outputs_i ? drive_i : level_reg;
		count_next = count_reg;
		if (preload_i) begin
			count_next = preload_val_i;
		end else if (src && !src_prev_reg && count_reg != {CNT_W{1'b1}}) begin
			count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		err_next = check_en_i && (count_reg > limit_i);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			level_reg <= 1'b0;
			changed_reg <= 1'b0;
			hold_reg <= 12'h000;
			src_prev_reg <= 1'b0;
			count_reg <= {CNT_W{1'b0}};
			err_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			level_reg <= level_next;
			changed_reg <= changed_next;
			hold_reg <= hold_next;
			src_prev_reg <= src;
			count_reg <= count_next;
			err_reg <= err_next;
		end
	end

	assign level_o = level_reg;
	assign changed_o = changed_reg;
	assign cnt_err_o = err_reg;
	assign count_o = count_reg;

endmodule // ics_chan_mon

`default_nettype wire

// *** rtl/ics_top.sv ***
/*
 * I/O channel supervision: input hold, output short and open-load errors,
 * fallback on fieldbus fault or idle, ON counters, analogue set-up.
 * Assumes the fieldbus core drives comm_fault_i and comm_idle_i on clk_i and
 * that software stores the counts in non-volatile memory on each save event.
 */
// Added by the designer: the Avalon-MM slave port and the register offsets.
`default_nettype none

module ics_top import ics_pkg::*; #(
	parameter int N_CH = 8,
	parameter int TICK_CYC = TICK_CYC_DEF,
	parameter int SAVE_TICKS = SAVE_TICKS_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	// Digital channels and sense pins
	input wire logic [N_CH-1:0] din_i,
	input wire logic [N_CH-1:0] open_sense_i,
	input wire logic short_sense_i,
	input wire logic supply_short_i,
	output logic [N_CH-1:0] dout_o,
	// Fieldbus state
	input wire logic comm_fault_i,
	input wire logic comm_idle_i,
	output logic save_req_o,
	// Analogue unit
	input wire logic adc_valid_i,
	input wire logic [15:0] adc_sample_i,
	output logic [3*N_CH-1:0] range_sel_o,
	output logic [15:0] adc_word_o,
	output logic adc_word_valid_o
);

	localparam int SEL_W = (N_CH > 1) ? $clog2(N_CH) : 1;

	ics_bus_state_type bus_reg, bus_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next, rd_mux, wmask;
	logic wr_go;
	ics_ctrl_type ctrl_reg, ctrl_next;
	logic [N_CH-1:0] out_data_reg, out_data_next;
	logic [2*N_CH-1:0] fault_fb_reg, fault_fb_next, idle_fb_reg, idle_fb_next;
	logic [15:0] limit_reg, limit_next;
	logic [SEL_W-1:0] sel_reg, sel_next;
	logic [3*N_CH-1:0] range_reg, range_next;
	logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next, events;
	logic irq_reg, irq_next;
	logic [31:0] limit_x;
	logic [11:0] hold_ticks;
	logic [N_CH+1:0] s1_reg, s2_reg;
	logic short_err_reg, short_err_next, supply_err_reg, supply_err_next;
	logic [N_CH-1:0] open_err_reg, open_err_next;
	logic [31:0] tick_cnt_reg, tick_cnt_next, save_cnt_reg, save_cnt_next;
	logic tick_reg, tick_next, save_reg, save_next;
	logic [N_CH-1:0] dout_reg, dout_next, level, changed, cnt_err, preload;
	logic [31:0] counts [N_CH];
	logic [15:0] adc_reg, adc_next, mag;
	logic adc_v_reg;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
		merge = (old & ~m) | (avs_writedata_i & m);
	endfunction

	function automatic logic fallback(input logic [1:0] fb, input logic cur);
		case (fb)
			FB_HOLD: fallback = cur;
			FB_DRIVE_ON_FORCED: fallback = 1'b1;
			default: fallback = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// Avalon slave: one wait cycle, then a single acknowledge cycle
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wr_go = (bus_reg == BUS_ACK) && avs_write_i;

	always_comb begin
		case (avs_address_i)
			ADDR_CTRL: rd_mux = 32'(ctrl_reg);
			ADDR_OUT_DATA: rd_mux = 32'(out_data_reg);
			ADDR_FAULT_FB: rd_mux = 32'(fault_fb_reg);
			ADDR_IDLE_FB: rd_mux = 32'(idle_fb_reg);
			ADDR_CNT_LIMIT: rd_mux = 32'(limit_reg);
			ADDR_CNT_SEL: rd_mux = 32'(sel_reg);
			ADDR_CNT_DATA: rd_mux = counts[sel_reg];
			ADDR_RANGE: rd_mux = 32'(range_reg);
			ADDR_IN_STATE: rd_mux = 32'(level);
			ADDR_UNIT_ERR: rd_mux = 32'({supply_err_reg, short_err_reg});
			ADDR_OPEN_ERR: rd_mux = 32'(open_err_reg);
			ADDR_CNT_ERR: rd_mux = 32'(cnt_err);
			ADDR_IRQ_STAT: rd_mux = 32'(stat_reg);
			ADDR_IRQ_MASK: rd_mux = 32'(mask_reg);
			default: rd_mux = 32'h0000_0000;
		endcase
		bus_next = BUS_IDLE;
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		case (bus_reg)
			BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					bus_next = BUS_ACK;
					wait_next = 1'b0;
					rdata_next = avs_read_i ? rd_mux : 32'h0000_0000;
				end
			end
			BUS_ACK: bus_next = BUS_IDLE;
			default: bus_next = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_reg <= BUS_IDLE;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			bus_reg <= bus_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// Configuration registers and interrupt status
	always_comb begin
		ctrl_next = ctrl_reg;
		out_data_next = out_data_reg;
		fault_fb_next = fault_fb_reg;
		idle_fb_next = idle_fb_reg;
		limit_next = limit_reg;
		sel_next = sel_reg;
		range_next = range_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		if (wr_go) begin
			case (avs_address_i)
				ADDR_CTRL: ctrl_next = CTRL_W'(merge(32'(ctrl_reg), wmask));
				ADDR_OUT_DATA: out_data_next = N_CH'(merge(32'(out_data_reg), wmask));
				ADDR_FAULT_FB: fault_fb_next = (2*N_CH)'(merge(32'(fault_fb_reg), wmask));
				ADDR_IDLE_FB: idle_fb_next = (2*N_CH)'(merge(32'(idle_fb_reg), wmask));
				ADDR_CNT_LIMIT: limit_next = 16'(merge(32'(limit_reg), wmask));
				ADDR_CNT_SEL: sel_next = SEL_W'(merge(32'(sel_reg), wmask));
				ADDR_RANGE: range_next = (3*N_CH)'(merge(32'(range_reg), wmask));
				ADDR_IRQ_MASK: mask_next = IRQ_W'(merge(32'(mask_reg), wmask));
				ADDR_IRQ_STAT: stat_next = stat_reg & ~IRQ_W'(avs_writedata_i & wmask);
				default: ;
			endcase
		end
		// A new event outranks a clear written in the same cycle.
		stat_next = stat_next | events;
		irq_next = |(stat_next & mask_next);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= CTRL_RST;
			out_data_reg <= '0;
			fault_fb_reg <= '0;
			idle_fb_reg <= '0;
			limit_reg <= CNT_LIMIT_RST;
			sel_reg <= '0;
			range_reg <= '0;
			mask_reg <= '0;
			stat_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			out_data_reg <= out_data_next;
			fault_fb_reg <= fault_fb_next;
			idle_fb_reg <= idle_fb_next;
			limit_reg <= limit_next;
			sel_reg <= sel_next;
			range_reg <= range_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================
	// Sense pins, error flags and time base
	always_comb begin
		// Disabling detection drops a latched short error as well.
		short_err_next = 1'b0;
		if (ctrl_reg.output_short_detect_en) begin
			if (s2_reg[0]) begin
				short_err_next = 1'b1;
			end else if (ctrl_reg.short_restart_policy == SHORT_POLICY_MANUAL) begin
				short_err_next = short_err_reg;
			end else begin
				short_err_next = 1'b0;
			end
		end
		supply_err_next = ctrl_reg.supply_short_detect_en && s2_reg[1];
		open_err_next = ctrl_reg.open_load_detect_en ? s2_reg[N_CH+1:2] : '0;
		events = '0;
		events[IRQ_SHORT] = short_err_next && !short_err_reg;
		events[IRQ_SUPPLY] = supply_err_next && !supply_err_reg;
		events[IRQ_OPEN] = |(open_err_next & ~open_err_reg);
		events[IRQ_COUNT] = |cnt_err;
		events[IRQ_SAVE] = save_reg;
		events[IRQ_INPUT] = |changed;
		tick_next = (tick_cnt_reg == 32'(TICK_CYC - 1));
		tick_cnt_next = tick_next ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
		save_next = 1'b0;
		save_cnt_next = save_cnt_reg;
		if (tick_reg) begin
			save_next = (save_cnt_reg == 32'(SAVE_TICKS - 1));
			save_cnt_next = save_next ? 32'h0000_0000 : save_cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			short_err_reg <= 1'b0;
			supply_err_reg <= 1'b0;
			open_err_reg <= '0;
			tick_cnt_reg <= 32'h0000_0000;
			save_cnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
			save_reg <= 1'b0;
		end else begin
			s1_reg <= {open_sense_i, supply_short_i, short_sense_i};
			s2_reg <= s1_reg;
			short_err_reg <= short_err_next;
			supply_err_reg <= supply_err_next;
			open_err_reg <= open_err_next;
			tick_cnt_reg <= tick_cnt_next;
			save_cnt_reg <= save_cnt_next;
			tick_reg <= tick_next;
			save_reg <= save_next;
		end
	end

	// ==========================================================
	// Channels and output drive
	always_comb begin
		case (ctrl_reg.input_hold_time_sel)
			HOLD_1MS: hold_ticks = HOLD_TICKS_1MS;
			HOLD_100MS: hold_ticks = HOLD_TICKS_100MS;
			HOLD_200MS: hold_ticks = HOLD_TICKS_200MS;
			default: hold_ticks = HOLD_TICKS_15MS;
		endcase
	end

	assign limit_x = 32'(limit_reg) * CNT_SCALE;

	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		logic [1:0] ffb, ifb;
		assign ffb = fault_fb_reg[2*g +: 2];
		assign ifb = idle_fb_reg[2*g +: 2];
		assign preload[g] = wr_go && (avs_address_i == ADDR_CNT_DATA) && (sel_reg == SEL_W'(g));
		always_comb begin
			if (ctrl_reg.hold_prio_handheld && comm_fault_i) begin
				dout_next[g] = fallback(ffb, dout_reg[g]);
			end else if (ctrl_reg.hold_prio_handheld && comm_idle_i) begin
				dout_next[g] = fallback(ifb, dout_reg[g]);
			end else if (comm_fault_i || comm_idle_i) begin
				dout_next[g] = 1'b0;
			end else begin
				dout_next[g] = out_data_reg[g];
			end
		end
		ics_chan_mon #(.CNT_W(32)) u_mon (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.pin_i(din_i[g]),
			.drive_i(dout_reg[g]),
			.tick_i(tick_reg),
			.hold_ticks_i(hold_ticks),
			.count_outputs_i(ctrl_reg.count_outputs),
			.check_en_i(ctrl_reg.counter_check_en),
			.preload_i(preload[g]),
			.preload_val_i(avs_writedata_i),
			.limit_i(limit_x),
			.level_o(level[g]),
			.changed_o(changed[g]),
			.cnt_err_o(cnt_err[g]),
			.count_o(counts[g])
		);
	end

	// ==========================================================
	// Analogue data word encoding
	always_comb begin
		if (adc_sample_i == ADC_MIN) begin
			mag = ADC_MAG_MAX;
		end else begin
			mag = adc_sample_i[15] ? 16'(-adc_sample_i) : adc_sample_i;
		end
		case (ctrl_reg.data_format)
			FMT_SIGN_MAG: adc_next = {adc_sample_i[15], mag[14:0]};
			FMT_TWOS_COMP: adc_next = adc_sample_i;
			default: adc_next = {~adc_sample_i[15], adc_sample_i[14:0]};
		endcase
		if (!adc_valid_i) begin
			adc_next = adc_reg;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dout_reg <= '0;
			adc_reg <= 16'h0000;
			adc_v_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			adc_reg <= adc_next;
			adc_v_reg <= adc_valid_i;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign irq_o = irq_reg;
	assign dout_o = dout_reg;
	assign save_req_o = save_reg;
	assign range_sel_o = range_reg;
	assign adc_word_o = adc_reg;
	assign adc_word_valid_o = adc_v_reg;

endmodule // ics_top

`default_nettype wire

// *** verif/ics_top_asserts.sv ***
/*
 * Port checker for the I/O channel supervision block.
 * Assumes it is bound to ics_top and shares its parameters.
 */
`default_nettype none

module ics_top_chk import ics_pkg::*; #(
	parameter int N_CH = 8,
	parameter int TICK_CYC = 4,
	parameter int SAVE_TICKS = 5
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Field side
	input wire logic [N_CH-1:0] dout_o,
	input wire logic comm_fault_i,
	input wire logic comm_idle_i,
	input wire logic save_req_o,
	input wire logic adc_valid_i,
	input wire logic adc_word_valid_o,
	input wire logic [3*N_CH-1:0] range_sel_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Helper logic
	logic [31:0] gap_reg, gap_next;
	logic seen_reg, seen_next;
	logic wr_rng;
	assign wr_rng = avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_RANGE;
	always_comb begin
		gap_next = save_req_o ? 32'h0 : gap_reg + 32'h1;
		seen_next = seen_reg | save_req_o;
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_reg <= 32'h0;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= gap_next;
			seen_reg <= seen_next;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_wait_one;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_wait_cause;
		$fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	property p_adc_valid;
		!$past(sys_rst_i) |-> adc_word_valid_o == $past(adc_valid_i);
	endproperty
	a_adc_valid: assert property (p_adc_valid) else $error("word valid lag wrong");
	property p_save_pulse;
		save_req_o |=> !save_req_o;
	endproperty
	a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
	property p_save_gap;
		save_req_o && seen_reg |-> gap_reg == 32'(SAVE_TICKS * TICK_CYC - 1);
	endproperty
	a_save_gap: assert property (p_save_gap) else $error("save period wrong");
	property p_fault_hold;
		comm_fault_i && $past(comm_fault_i) && $past(comm_fault_i, 2) && !$past(sys_rst_i)
			&& !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3) |-> $stable(dout_o);
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("drive moved in fault");
	property p_idle_hold;
		(comm_idle_i && !comm_fault_i) [*3] ##0 !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3)
			|-> $stable(dout_o);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("drive moved in idle");
	property p_range_src;
		$changed(range_sel_o) |-> $past(wr_rng) || $past(wr_rng, 2);
	endproperty
	a_range_src: assert property (p_range_src) else $error("range moved unasked");

endmodule // ics_top_chk

bind ics_top ics_top_chk #(.N_CH(N_CH), .TICK_CYC(TICK_CYC), .SAVE_TICKS(SAVE_TICKS)) i_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.dout_o(dout_o), .comm_fault_i(comm_fault_i), .comm_idle_i(comm_idle_i),
	.save_req_o(save_req_o), .adc_valid_i(adc_valid_i), .adc_word_valid_o(adc_word_valid_o),
	.range_sel_o(range_sel_o)
);

`default_nettype wire

// *** verif/ics_field_model.sv ***
/*
 * Field side load model: a shorted load on command and a lamp load.
 * Assumes the bench drives its commands on the rising clock edge.
 */
`default_nettype none

module ics_field_model (
	// Clock
	input wire logic clk_i,
	// Load
	input wire logic dout0_i,
	input wire logic lamp_i,
	input wire logic short_cmd_i,
	output logic short_sense_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// A cold lamp draws inrush current that looks like a short for a while.
	logic [3:0] inrush = 4'h0;
	logic last = 1'b0;
	always @(posedge clk_i) begin
		last <= dout0_i;
		if (lamp_i && dout0_i && !last)
			inrush <= 4'hf;
		else if (inrush != 4'h0)
			inrush <= inrush - 4'h1;
	end
	assign short_sense_o = short_cmd_i | (inrush != 4'h0);

endmodule // ics_field_model

`default_nettype wire

// *** verif/tb.sv ***
/*
 * Self-checking bench for ics_top over its Avalon-MM registers.
 * Assumes short tick and save parameters so that the run stays brief.
 */
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb import ics_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int TICK_T = 4;
	localparam int SAVE_T = 5;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, irq_o, save_req_o, adc_word_valid_o, short_sense;
	logic [7:0] din_i = 8'h0;
	logic [7:0] open_sense_i = 8'h0;
	logic [7:0] dout_o;
	logic short_cmd = 1'b0;
	logic lamp = 1'b0;
	logic supply_short_i = 1'b0;
	logic comm_fault_i = 1'b0;
	logic comm_idle_i = 1'b0;
	logic adc_valid_i = 1'b0;
	logic [15:0] adc_sample_i = 16'h0;
	logic [15:0] adc_word_o;
	logic [23:0] range_sel_o;
	logic [15:0] fmt_exp [3] = '{16'h7ffb, 16'h8005, 16'hfffb};
	int n_errors = 0;
	int checks_done = 0;

	always #2.5 clk_i = ~clk_i;

	ics_top #(.N_CH(8), .TICK_CYC(TICK_T), .SAVE_TICKS(SAVE_T)) i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .din_i(din_i),
		.open_sense_i(open_sense_i), .short_sense_i(short_sense),
		.supply_short_i(supply_short_i), .dout_o(dout_o), .comm_fault_i(comm_fault_i),
		.comm_idle_i(comm_idle_i), .save_req_o(save_req_o), .adc_valid_i(adc_valid_i),
		.adc_sample_i(adc_sample_i), .range_sel_o(range_sel_o), .adc_word_o(adc_word_o),
		.adc_word_valid_o(adc_word_valid_o)
	);

	ics_field_model i_field (.clk_i(clk_i), .dout0_i(dout_o[0]), .lamp_i(lamp),
		.short_cmd_i(short_cmd), .short_sense_o(short_sense));

	// ==========================================================
	// Bus and helper tasks
	// Just after a rising edge the registered slave outputs still show what the edge before it
	// sampled, so waitrequest and read data are taken there; a stuck slave is left to the
	// watchdog.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(nm, e, q)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic sdout(input string nm, input logic [7:0] e);
		look(3);
		`CHK(nm, e, dout_o)
		@(posedge clk_i);
	endtask
	task automatic toggle();
		wr(ADDR_OUT_DATA, 32'h1);
		wr(ADDR_OUT_DATA, 32'h0);
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		cyc(4);
		sys_rst_i <= 1'b0;
	endtask
	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		logic [7:0] exp;
		int t;
		cyc(4);
		sys_rst_i <= 1'b0;
		rdc("ctrl", ADDR_CTRL, 32'h089);
		rdc("limit", ADDR_CNT_LIMIT, 32'h0000fde8);
		rdc("range0", ADDR_RANGE, 32'h0);
		wr(8'h3c, 32'hffffffff);
		rdc("unmapped", 8'h3c, 32'h0);
		tend("reset");
		wr(ADDR_IRQ_MASK, 32'h1);
		short_cmd <= 1'b1;
		cyc(6);
		rdc("short", ADDR_UNIT_ERR, 32'h1);
		look(1);
		`CHK("irq_set", 1'b1, irq_o)
		@(posedge clk_i);
		short_cmd <= 1'b0;
		cyc(6);
		rdc("short_auto", ADDR_UNIT_ERR, 32'h0);
		wr(ADDR_IRQ_STAT, 32'h1);
		look(2);
		`CHK("irq_clr", 1'b0, irq_o)
		wr(ADDR_CTRL, 32'h08b);
		short_cmd <= 1'b1;
		cyc(6);
		short_cmd <= 1'b0;
		cyc(6);
		rdc("short_man", ADDR_UNIT_ERR, 32'h1);
		look(1);
		`CHK("irq_man", 1'b1, irq_o)
		wr(ADDR_IRQ_MASK, 32'h0);
		look(2);
		`CHK("irq_mask", 1'b0, irq_o)
		do_reset();
		rdc("short_rst", ADDR_UNIT_ERR, 32'h0);
		wr(ADDR_CTRL, 32'h088);
		lamp <= 1'b1;
		wr(ADDR_OUT_DATA, 32'h1);
		cyc(4);
		rdc("lamp", ADDR_UNIT_ERR, 32'h0);
		lamp <= 1'b0;
		open_sense_i <= 8'h08;
		supply_short_i <= 1'b1;
		cyc(6);
		rdc("open_off", ADDR_OPEN_ERR, 32'h0);
		rdc("supply", ADDR_UNIT_ERR, 32'h2);
		wr(ADDR_CTRL, 32'h085);
		cyc(6);
		rdc("open_on", ADDR_OPEN_ERR, 32'h08);
		rdc("supply_off", ADDR_UNIT_ERR, 32'h0);
		open_sense_i <= 8'h0;
		supply_short_i <= 1'b0;
		tend("errors");
		wr(ADDR_OUT_DATA, 32'hf0);
		wr(ADDR_CTRL, 32'h0a9);
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_FAULT_FB, {16'h0, {8{m[1:0]}}});
			wr(ADDR_IDLE_FB, {16'h0, {8{m[1:0]}}});
			exp = (m == 0) ? 8'h00 : (m == 1) ? 8'hf0 : 8'hff;
			comm_fault_i <= 1'b1;
			sdout("fault_fb", exp);
			comm_fault_i <= 1'b0;
			comm_idle_i <= 1'b1;
			sdout("idle_fb", exp);
			comm_idle_i <= 1'b0;
			sdout("dout", 8'hf0);
		end
		wr(ADDR_CTRL, 32'h089);
		comm_fault_i <= 1'b1;
		sdout("fault_plc", 8'h00);
		comm_fault_i <= 1'b0;
		comm_idle_i <= 1'b1;
		sdout("idle_plc", 8'h00);
		comm_idle_i <= 1'b0;
		tend("fallback");
		wr(ADDR_CTRL, 32'h009);
		din_i <= 8'h01;
		cyc(2);
		din_i <= 8'h00;
		cyc(4);
		rdc("hold_on", ADDR_IN_STATE, 32'h1);
		cyc(50);
		rdc("hold_off", ADDR_IN_STATE, 32'h0);
		tend("hold");
		wr(ADDR_CTRL, 32'h0d9);
		wr(ADDR_OUT_DATA, 32'h0);
		wr(ADDR_CNT_SEL, 32'h0);
		wr(ADDR_CNT_LIMIT, 32'h1);
		wr(ADDR_CNT_DATA, 32'd999);
		rdc("preload", ADDR_CNT_DATA, 32'd999);
		toggle();
		rdc("cnt_err0", ADDR_CNT_ERR, 32'h0);
		toggle();
		rdc("cnt_err1", ADDR_CNT_ERR, 32'h1);
		rdc("count", ADDR_CNT_DATA, 32'd1001);
		wr(ADDR_CNT_DATA, 32'hffffffff);
		toggle();
		rdc("saturate", ADDR_CNT_DATA, 32'hffffffff);
		t = 0;
		do begin
			@(negedge clk_i);
			t++;
		end while (save_req_o !== 1'b1 && t < 100);
		t = 0;
		do begin
			@(negedge clk_i);
			t++;
		end while (save_req_o !== 1'b1 && t < 100);
		`CHK("save_gap", SAVE_T * TICK_T, t)
		rdc("irq_stat", ADDR_IRQ_STAT, 32'h3e);
		tend("counter");
		for (int f = 0; f < 3; f++) begin
			wr(ADDR_CTRL, 32'h089 | (f << 9));
			adc_sample_i <= 16'hfffb;
			adc_valid_i <= 1'b1;
			@(posedge clk_i);
			adc_valid_i <= 1'b0;
			@(negedge clk_i);
			`CHK("adc_valid", 1'b1, adc_word_valid_o)
			`CHK("adc_word", fmt_exp[f], adc_word_o)
		end
		wr(ADDR_RANGE, 32'hfac688);
		rdc("range", ADDR_RANGE, 32'hfac688);
		`CHK("range_pins", 24'hfac688, range_sel_o)
		tend("analogue");
		test_done();
	end

	initial begin
		cyc(20000);
		n_errors++;
		test_done();
	end

endmodule // tb

`default_nettype wire
